/* File: hw/ammlg_top.sv */
// Purpose: Alarm gathering, alarm output masking and output mute request
// Assumes: Event inputs come from logic on clk_i and are one-cycle pulses
// Notes:   Neighbour alarm bytes are mirrored read-only for convenience
module ammlg_top
  import ammlg_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic        trig_realign_i,
  input  wire logic        sysref_edge_i,
  input  wire logic        sysref_on_align_i,
  input  wire logic        sysref_align_enable_i,
  input  wire logic        clk_realign_i,
  input  wire logic [3:0]  fifo_empty_alarm_i,
  input  wire logic [3:0]  fifo_full_alarm_i,
  input  wire logic [3:0]  lane_clock_loss_alarm_i,
  input  wire logic [3:0]  strobe_position_alarm_i,
  output logic [7:0]       rdata_o,
  output logic             alarm_o,
  output logic             mute_o,
  output logic [7:0]       alarm_output_mask_o,
  output logic [7:0]       output_mute_mask_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [4:0] sys_reserved;
    logic [7:0] alarm_output_mask;
    logic [7:0] output_mute_mask;
    logic [7:0] rdata;
    logic       alarm;
    logic       mute;
  } ammlg_state_t;

  ammlg_state_t state;
  ammlg_state_t next_state;

  logic [AMMLG_NUM_SYS_FLAGS-1:0] sys_set;
  logic [AMMLG_NUM_SYS_FLAGS-1:0] sys_clr;
  logic [AMMLG_NUM_SYS_FLAGS-1:0] sys_flags;
  logic [7:0]                     system_alarm_flags;
  logic                           fifo_any;
  logic                           lane_any;
  logic                           strobe_any;
  logic [7:0]                     alarm_sources;
  logic                           wr_sys;

  // ----------------------------------------
  // Flag sources
  // ----------------------------------------
  // Misalign only counts while alignment is not enabled; with alignment on,
  // an off-position edge is the expected realignment, not a fault.
  always_comb
  begin
    sys_set[AMMLG_BIT_TRIG_REALIGN] = trig_realign_i;
    sys_set[AMMLG_BIT_MISALIGN]     = sysref_edge_i && !sysref_on_align_i
                                      && !sysref_align_enable_i;
    sys_set[AMMLG_BIT_CLK_REALIGN]  = clk_realign_i;
  end

  assign wr_sys = wr_i && (addr_i == AMMLG_SYS_ALARM_ADDR);

  genvar g;
  generate
    for (g = 0; g < AMMLG_NUM_SYS_FLAGS; g++)
    begin : g_flag
      assign sys_clr[g] = wr_sys && wdata_i[g];
      ammlg_flag u_flag (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .set_i  (sys_set[g]),
        .clr_i  (sys_clr[g]),
        .flag_o (sys_flags[g])
      );
    end
  endgenerate

  assign system_alarm_flags = {state.sys_reserved, sys_flags};

  // Per-bank alarms are already sticky in the neighbour status logic.
  assign fifo_any   = |{fifo_empty_alarm_i, fifo_full_alarm_i};
  assign lane_any   = |lane_clock_loss_alarm_i;
  assign strobe_any = |strobe_position_alarm_i;

  always_comb
  begin
    alarm_sources                         = AMMLG_ZERO_BYTE;
    alarm_sources[AMMLG_BIT_FIFO]         = fifo_any;
    alarm_sources[AMMLG_BIT_LANE_CLK]     = lane_any;
    alarm_sources[AMMLG_BIT_STROBE]       = strobe_any;
    alarm_sources[AMMLG_BIT_TRIG_REALIGN] = sys_flags[AMMLG_BIT_TRIG_REALIGN];
    alarm_sources[AMMLG_BIT_MISALIGN]     = sys_flags[AMMLG_BIT_MISALIGN];
    alarm_sources[AMMLG_BIT_CLK_REALIGN]  = sys_flags[AMMLG_BIT_CLK_REALIGN];
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_state       = state;
    next_state.rdata = AMMLG_ZERO_BYTE;
    if (wr_i)
    begin
      case (addr_i)
        AMMLG_SYS_ALARM_ADDR:
        begin
          next_state.sys_reserved = wdata_i[7:3];
        end
        AMMLG_ALARM_OUTPUT_MASK_ADDR:
        begin
          next_state.alarm_output_mask = wdata_i;
        end
        AMMLG_MUTE_MASK_ADDR:
        begin
          next_state.output_mute_mask = wdata_i;
        end
        default:
        begin
          next_state.rdata = AMMLG_ZERO_BYTE;
        end
      endcase
    end
    if (rd_i)
    begin
      case (addr_i)
        AMMLG_SYS_ALARM_ADDR: next_state.rdata = system_alarm_flags;
        AMMLG_ALARM_OUTPUT_MASK_ADDR:  next_state.rdata = state.alarm_output_mask;
        AMMLG_MUTE_MASK_ADDR: next_state.rdata = state.output_mute_mask;
        AMMLG_NEIGH_ADDR0:    next_state.rdata = {fifo_empty_alarm_i, fifo_full_alarm_i};
        AMMLG_NEIGH_ADDR1:
        begin
          next_state.rdata = {lane_clock_loss_alarm_i, strobe_position_alarm_i};
        end
        default:              next_state.rdata = AMMLG_ZERO_BYTE;
      endcase
    end
    // Reserved mask bits 4..3 have no source, so they never gate anything.
    next_state.alarm = |(alarm_sources & ~state.alarm_output_mask);
    next_state.mute  = |(alarm_sources & ~state.output_mute_mask);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state.sys_reserved      <= '0;
      state.alarm_output_mask <= AMMLG_ALARM_OUTPUT_MASK_RST;
      state.output_mute_mask  <= AMMLG_MUTE_MASK_RST;
      state.rdata             <= AMMLG_ZERO_BYTE;
      state.alarm             <= 1'b0;
      state.mute              <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign rdata_o             = state.rdata;
  assign alarm_o             = state.alarm;
  assign mute_o              = state.mute;
  assign alarm_output_mask_o = state.alarm_output_mask;
  assign output_mute_mask_o  = state.output_mute_mask;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Open sources after each mask; a masked source must never reach its output
  logic [7:0] alarm_open;
  logic [7:0] mute_open;

  assign alarm_open = alarm_sources & ~state.alarm_output_mask;
  assign mute_open  = alarm_sources & ~state.output_mute_mask;

  a_trig_sets_flag: assert property (@(posedge clk_i) disable iff (srst_i)
    trig_realign_i |=> sys_flags[AMMLG_BIT_TRIG_REALIGN])
    else $error("trigger realign flag not set");

  a_trig_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
    (!sys_flags[AMMLG_BIT_TRIG_REALIGN] && !trig_realign_i)
    |=> !sys_flags[AMMLG_BIT_TRIG_REALIGN])
    else $error("trigger realign flag set without an event");

  a_misalign_sets: assert property (@(posedge clk_i) disable iff (srst_i)
    (sysref_edge_i && !sysref_on_align_i && !sysref_align_enable_i)
    |=> sys_flags[AMMLG_BIT_MISALIGN])
    else $error("misalign flag not set");

  a_misalign_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
    (!sys_flags[AMMLG_BIT_MISALIGN] && sysref_align_enable_i)
    |=> !sys_flags[AMMLG_BIT_MISALIGN])
    else $error("misalign flag set while alignment enabled");

  a_clk_realign: assert property (@(posedge clk_i) disable iff (srst_i)
    clk_realign_i |=> sys_flags[AMMLG_BIT_CLK_REALIGN])
    else $error("clock realign flag not set");

  a_clk_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
    (!sys_flags[AMMLG_BIT_CLK_REALIGN] && !clk_realign_i)
    |=> !sys_flags[AMMLG_BIT_CLK_REALIGN])
    else $error("clock realign flag set without an event");

  a_w1c_clears: assert property (@(posedge clk_i) disable iff (srst_i)
    (wr_sys && wdata_i[0] && !sys_set[0]) |=> !sys_flags[0])
    else $error("write one did not clear flag");

  a_w1c_misalign: assert property (@(posedge clk_i) disable iff (srst_i)
    (wr_sys && wdata_i[AMMLG_BIT_MISALIGN] && !sys_set[AMMLG_BIT_MISALIGN])
    |=> !sys_flags[AMMLG_BIT_MISALIGN])
    else $error("write one did not clear misalign flag");

  a_w1c_trig: assert property (@(posedge clk_i) disable iff (srst_i)
    (wr_sys && wdata_i[AMMLG_BIT_TRIG_REALIGN] && !sys_set[AMMLG_BIT_TRIG_REALIGN])
    |=> !sys_flags[AMMLG_BIT_TRIG_REALIGN])
    else $error("write one did not clear trigger realign flag");

  a_zero_keeps: assert property (@(posedge clk_i) disable iff (srst_i)
    (wr_sys && (sys_flags & wdata_i[AMMLG_NUM_SYS_FLAGS-1:0]) == 3'h0)
    |=> (($past(sys_flags) & ~sys_flags) == 3'h0))
    else $error("write of zero cleared a flag");

  a_fifo_alarm: assert property (@(posedge clk_i) disable iff (srst_i)
    alarm_open[AMMLG_BIT_FIFO] |=> alarm_o)
    else $error("unmasked fifo alarm not on output");

  a_lane_alarm: assert property (@(posedge clk_i) disable iff (srst_i)
    alarm_open[AMMLG_BIT_LANE_CLK] |=> alarm_o)
    else $error("unmasked lane clock alarm not on output");

  a_strobe_alarm: assert property (@(posedge clk_i) disable iff (srst_i)
    alarm_open[AMMLG_BIT_STROBE] |=> alarm_o)
    else $error("unmasked strobe alarm not on output");

  a_trig_alarm: assert property (@(posedge clk_i) disable iff (srst_i)
    alarm_open[AMMLG_BIT_TRIG_REALIGN] |=> alarm_o)
    else $error("unmasked trigger realign flag not on output");

  a_misalign_alarm: assert property (@(posedge clk_i) disable iff (srst_i)
    alarm_open[AMMLG_BIT_MISALIGN] |=> alarm_o)
    else $error("unmasked misalign flag not on output");

  a_realign_alarm: assert property (@(posedge clk_i) disable iff (srst_i)
    alarm_open[AMMLG_BIT_CLK_REALIGN] |=> alarm_o)
    else $error("unmasked clock realign flag not on output");

  a_fifo_alarm_off: assert property (@(posedge clk_i) disable iff (srst_i)
    (alarm_sources[AMMLG_BIT_FIFO] && alarm_open == AMMLG_ZERO_BYTE) |=> !alarm_o)
    else $error("masked fifo alarm reached output");

  a_lane_alarm_off: assert property (@(posedge clk_i) disable iff (srst_i)
    (alarm_sources[AMMLG_BIT_LANE_CLK] && alarm_open == AMMLG_ZERO_BYTE) |=> !alarm_o)
    else $error("masked lane clock alarm reached output");

  a_strobe_alarm_off: assert property (@(posedge clk_i) disable iff (srst_i)
    (alarm_sources[AMMLG_BIT_STROBE] && alarm_open == AMMLG_ZERO_BYTE) |=> !alarm_o)
    else $error("masked strobe alarm reached output");

  a_trig_alarm_off: assert property (@(posedge clk_i) disable iff (srst_i)
    (alarm_sources[AMMLG_BIT_TRIG_REALIGN] && alarm_open == AMMLG_ZERO_BYTE) |=> !alarm_o)
    else $error("masked trigger realign flag reached output");

  a_misalign_alarm_off: assert property (@(posedge clk_i) disable iff (srst_i)
    (alarm_sources[AMMLG_BIT_MISALIGN] && alarm_open == AMMLG_ZERO_BYTE) |=> !alarm_o)
    else $error("masked misalign flag reached output");

  a_realign_alarm_off: assert property (@(posedge clk_i) disable iff (srst_i)
    (alarm_sources[AMMLG_BIT_CLK_REALIGN] && alarm_open == AMMLG_ZERO_BYTE) |=> !alarm_o)
    else $error("masked clock realign flag reached output");

  a_fifo_mute: assert property (@(posedge clk_i) disable iff (srst_i)
    mute_open[AMMLG_BIT_FIFO] |=> mute_o)
    else $error("unmasked fifo alarm did not mute");

  a_lane_mute: assert property (@(posedge clk_i) disable iff (srst_i)
    mute_open[AMMLG_BIT_LANE_CLK] |=> mute_o)
    else $error("unmasked lane clock alarm did not mute");

  a_strobe_mute: assert property (@(posedge clk_i) disable iff (srst_i)
    mute_open[AMMLG_BIT_STROBE] |=> mute_o)
    else $error("unmasked strobe alarm did not mute");

  a_trig_mute: assert property (@(posedge clk_i) disable iff (srst_i)
    mute_open[AMMLG_BIT_TRIG_REALIGN] |=> mute_o)
    else $error("unmasked trigger realign flag did not mute");

  a_misalign_mute: assert property (@(posedge clk_i) disable iff (srst_i)
    mute_open[AMMLG_BIT_MISALIGN] |=> mute_o)
    else $error("unmasked misalign flag did not mute");

  a_realign_mute: assert property (@(posedge clk_i) disable iff (srst_i)
    mute_open[AMMLG_BIT_CLK_REALIGN] |=> mute_o)
    else $error("unmasked clock realign flag did not mute");

  a_fifo_mute_off: assert property (@(posedge clk_i) disable iff (srst_i)
    (alarm_sources[AMMLG_BIT_FIFO] && mute_open == AMMLG_ZERO_BYTE) |=> !mute_o)
    else $error("masked fifo alarm muted output");

  a_lane_mute_off: assert property (@(posedge clk_i) disable iff (srst_i)
    (alarm_sources[AMMLG_BIT_LANE_CLK] && mute_open == AMMLG_ZERO_BYTE) |=> !mute_o)
    else $error("masked lane clock alarm muted output");

  a_strobe_mute_off: assert property (@(posedge clk_i) disable iff (srst_i)
    (alarm_sources[AMMLG_BIT_STROBE] && mute_open == AMMLG_ZERO_BYTE) |=> !mute_o)
    else $error("masked strobe alarm muted output");

  a_trig_mute_off: assert property (@(posedge clk_i) disable iff (srst_i)
    (alarm_sources[AMMLG_BIT_TRIG_REALIGN] && mute_open == AMMLG_ZERO_BYTE) |=> !mute_o)
    else $error("masked trigger realign flag muted output");

  a_misalign_mute_off: assert property (@(posedge clk_i) disable iff (srst_i)
    (alarm_sources[AMMLG_BIT_MISALIGN] && mute_open == AMMLG_ZERO_BYTE) |=> !mute_o)
    else $error("masked misalign flag muted output");

  a_realign_mute_off: assert property (@(posedge clk_i) disable iff (srst_i)
    (alarm_sources[AMMLG_BIT_CLK_REALIGN] && mute_open == AMMLG_ZERO_BYTE) |=> !mute_o)
    else $error("masked clock realign flag muted output");

  a_mute_reset: assert property (@(posedge clk_i)
    $fell(srst_i) |-> (output_mute_mask_o == AMMLG_MUTE_MASK_RST
    && alarm_output_mask_o == AMMLG_ALARM_OUTPUT_MASK_RST))
    else $error("mask reset values wrong");

  a_reset_quiet: assert property (@(posedge clk_i)
    $fell(srst_i) |-> (!alarm_o && !mute_o && system_alarm_flags == AMMLG_SYS_ALARM_RST))
    else $error("alarm state not cleared by reset");

  a_alarm_masked: assert property (@(posedge clk_i) disable iff (srst_i)
    (alarm_open == AMMLG_ZERO_BYTE) |=> !alarm_o)
    else $error("alarm output without a pending unmasked alarm");

  a_mute_follow: assert property (@(posedge clk_i) disable iff (srst_i)
    (mute_open == AMMLG_ZERO_BYTE) |=> !mute_o)
    else $error("mute without a pending unmasked alarm");

  a_read_idle: assert property (@(posedge clk_i) disable iff (srst_i)
    !rd_i |=> (rdata_o == AMMLG_ZERO_BYTE))
    else $error("read data stood without a read");

  a_read_reserved: assert property (@(posedge clk_i) disable iff (srst_i)
    (rd_i && addr_i == AMMLG_SYS_ALARM_ADDR) |=> (rdata_o[7:3] == $past(state.sys_reserved)))
    else $error("reserved alarm bits not read back");

  c_trig_alarm: cover property (@(posedge clk_i) disable iff (srst_i)
    trig_realign_i ##2 alarm_o);
  c_lane_mute: cover property (@(posedge clk_i) disable iff (srst_i)
    lane_any ##1 mute_o);
  c_clear_flag: cover property (@(posedge clk_i) disable iff (srst_i)
    sys_flags[0] ##1 (wr_sys && wdata_i[0]) ##1 !sys_flags[0]);

endmodule

/* File: pkg/ammlg_pkg.sv */
// Purpose: Constants for the alarm mask and mute logic
// Assumes: 20 MHz device clock, byte-wide registers on a plain port
// Notes:   Register offsets are byte addresses on the control port
//
// Summary of operation
// - Set trigger-divider realign flag, bit 2, when a reference edge realigns divider.
// - Set misalign flag, bit 1, on off-position reference edge while align disabled.
// - Set clock realign flag, bit 0, when reference edge or strobe realigns clocks.
// - Flags stay set until software writes one; writing zero leaves them.
// - Alarm mask bit 7 keeps FIFO level alarms off the alarm output.
// - Alarm mask bit 6 keeps lane clock loss alarms off the alarm output.
// - Alarm mask bit 5 keeps strobe position alarms off the alarm output.
// - Alarm mask bit 2 keeps trigger realign flag off the alarm output.
// - Alarm mask bit 1 keeps misalign flag off the alarm output.
// - Alarm mask bit 0 keeps clock realign flag off the alarm output.
// - FIFO level alarms mute output unless mute mask bit 7 set.
// - Lane clock loss alarms mute output unless mute mask bit 6 set.
// - Strobe position alarms mute output unless mute mask bit 5 set.
// - Trigger realign flag mutes unless mute mask bit 2; resets to one.
// - Misalign flag mutes unless mute mask bit 1; resets to one.
// - Clock realign flag mutes unless mute mask bit 0; resets to one.
// - After reset mute mask is 0x07 and alarm mask is 0x00.
// - Enabled banks raise their own FIFO almost-empty and almost-full alarms.
// - Configured banks raise lane clock loss on missing half of edges in eight periods.
// - Strobe at unexpected position raises per-bank strobe alarm, realigns unless locked.
package ammlg_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] AMMLG_SYS_ALARM_ADDR = 12'h0822;
  localparam logic [11:0] AMMLG_ALARM_OUTPUT_MASK_ADDR  = 12'h0823;
  localparam logic [11:0] AMMLG_MUTE_MASK_ADDR = 12'h0824;
  localparam logic [11:0] AMMLG_NEIGH_ADDR0    = 12'h0820;
  localparam logic [11:0] AMMLG_NEIGH_ADDR1    = 12'h0821;

  localparam logic [7:0] AMMLG_ALARM_OUTPUT_MASK_RST  = 8'h00;
  localparam logic [7:0] AMMLG_MUTE_MASK_RST = 8'h07;
  localparam logic [7:0] AMMLG_SYS_ALARM_RST = 8'h00;
  localparam logic [7:0] AMMLG_ZERO_BYTE     = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int AMMLG_BIT_CLK_REALIGN  = 0;
  localparam int AMMLG_BIT_MISALIGN     = 1;
  localparam int AMMLG_BIT_TRIG_REALIGN = 2;
  localparam int AMMLG_BIT_STROBE       = 5;
  localparam int AMMLG_BIT_LANE_CLK     = 6;
  localparam int AMMLG_BIT_FIFO         = 7;
  localparam int AMMLG_NUM_SYS_FLAGS    = 3;
  localparam int AMMLG_NUM_BANKS        = 4;

endpackage

/* File: hw/ammlg_flag.sv */
// Purpose: One sticky write-one-to-clear flag
// Assumes: Set and clear are single-cycle pulses on clk_i
// Notes:   Set wins over a clear in the same cycle
module ammlg_flag
  import ammlg_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);

  typedef struct packed {
    logic flag;
  } ammlg_flag_state_t;

  ammlg_flag_state_t state;
  ammlg_flag_state_t next_state;

  always_comb
  begin
    next_state = state;
    if (set_i)
    begin
      next_state.flag = 1'b1;
    end
    else if (clr_i)
    begin
      next_state.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign flag_o = state.flag;

  a_flag_sticky: assert property (@(posedge clk_i) disable iff (srst_i)
    (flag_o && !clr_i) |=> flag_o)
    else $error("sticky flag dropped without a clear");

endmodule

/* File: tb/ammlg_top_bench.sv */
// Purpose: Self-checking bench for the alarm mask and mute logic
// Assumes: Bench drives every port itself, register port with no wait states
// Notes:   Outputs are sampled 1 ns after an edge so the edge's updates land first
module ammlg_top_bench
  import ammlg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [11:0] addr_i = 12'h0000;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        trig_realign_i = 1'b0;
  logic        sysref_edge_i = 1'b0;
  logic        sysref_on_align_i = 1'b0;
  logic        sysref_align_enable_i = 1'b0;
  logic        clk_realign_i = 1'b0;
  logic [3:0]  fifo_empty_alarm_i = 4'h0;
  logic [3:0]  fifo_full_alarm_i = 4'h0;
  logic [3:0]  lane_clock_loss_alarm_i = 4'h0;
  logic [3:0]  strobe_position_alarm_i = 4'h0;
  logic [7:0]  rdata_o;
  logic        alarm_o;
  logic        mute_o;
  logic [7:0]  alarm_output_mask_o;
  logic [7:0]  output_mute_mask_o;
  int          errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  ammlg_top DUT (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .trig_realign_i(trig_realign_i),
    .sysref_edge_i(sysref_edge_i), .sysref_on_align_i(sysref_on_align_i),
    .sysref_align_enable_i(sysref_align_enable_i), .clk_realign_i(clk_realign_i),
    .fifo_empty_alarm_i(fifo_empty_alarm_i), .fifo_full_alarm_i(fifo_full_alarm_i),
    .lane_clock_loss_alarm_i(lane_clock_loss_alarm_i),
    .strobe_position_alarm_i(strobe_position_alarm_i), .rdata_o(rdata_o),
    .alarm_o(alarm_o), .mute_o(mute_o), .alarm_output_mask_o(alarm_output_mask_o),
    .output_mute_mask_o(output_mute_mask_o));

  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  // Whole run is well under a thousand cycles
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors = errors + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk("rdata_o", rdata_o, exp);
  endtask

  // Two edges cover flag-to-output and mask-to-output latency
  task automatic outs(input logic ea, input logic em);
    repeat (2) @(posedge clk_i);
    #1;
    chk("alarm_o", {7'h00, alarm_o}, {7'h00, ea});
    chk("mute_o", {7'h00, mute_o}, {7'h00, em});
  endtask

  task automatic ev(input int b);
    @(posedge clk_i);
    if (b == 0) clk_realign_i <= 1'b1;
    else if (b == 1) sysref_edge_i <= 1'b1;
    else trig_realign_i <= 1'b1;
    @(posedge clk_i);
    clk_realign_i  <= 1'b0;
    sysref_edge_i  <= 1'b0;
    trig_realign_i <= 1'b0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(AMMLG_SYS_ALARM_ADDR, 8'h00);
    rd(AMMLG_ALARM_OUTPUT_MASK_ADDR, 8'h00);
    rd(AMMLG_MUTE_MASK_ADDR, 8'h07);
    chk("output_mute_mask_o", output_mute_mask_o, 8'h07);
    outs(1'b0, 1'b0);
  endtask

  task automatic t_flags();
    for (int b = 0; b < 3; b++)
    begin
      ev(b);
      rd(AMMLG_SYS_ALARM_ADDR, 8'h01 << b);
      outs(1'b1, 1'b0);
      wr(AMMLG_SYS_ALARM_ADDR, ~(8'h01 << b) & 8'h07);
      rd(AMMLG_SYS_ALARM_ADDR, 8'h01 << b);
      wr(AMMLG_SYS_ALARM_ADDR, 8'h01 << b);
      rd(AMMLG_SYS_ALARM_ADDR, 8'h00);
      outs(1'b0, 1'b0);
    end
    // Misalign is not flagged while aligning or when the edge is on position
    sysref_align_enable_i <= 1'b1;
    ev(1);
    rd(AMMLG_SYS_ALARM_ADDR, 8'h00);
    sysref_align_enable_i <= 1'b0;
    sysref_on_align_i     <= 1'b1;
    ev(1);
    rd(AMMLG_SYS_ALARM_ADDR, 8'h00);
    sysref_on_align_i     <= 1'b0;
  endtask

  task automatic t_sysmask();
    wr(AMMLG_MUTE_MASK_ADDR, 8'h00);
    for (int b = 0; b < 3; b++)
    begin
      ev(b);
      outs(1'b1, 1'b1);
      wr(AMMLG_ALARM_OUTPUT_MASK_ADDR, 8'h01 << b);
      outs(1'b0, 1'b1);
      wr(AMMLG_MUTE_MASK_ADDR, 8'h01 << b);
      outs(1'b0, 1'b0);
      wr(AMMLG_ALARM_OUTPUT_MASK_ADDR, 8'h00);
      wr(AMMLG_SYS_ALARM_ADDR, 8'h07);
      wr(AMMLG_MUTE_MASK_ADDR, 8'h00);
      outs(1'b0, 1'b0);
    end
  endtask

  // Each neighbour alarm kind is raised on a different bank
  task automatic t_bank();
    logic [7:0] m;
    for (int k = 0; k < 4; k++)
    begin
      m = (k < 2) ? 8'h80 : ((k == 2) ? 8'h40 : 8'h20);
      fifo_empty_alarm_i[k]      <= (k == 0);
      fifo_full_alarm_i[k]       <= (k == 1);
      lane_clock_loss_alarm_i[k] <= (k == 2);
      strobe_position_alarm_i[k] <= (k == 3);
      outs(1'b1, 1'b1);
      rd(AMMLG_NEIGH_ADDR0, {fifo_empty_alarm_i, fifo_full_alarm_i});
      rd(AMMLG_NEIGH_ADDR1, {lane_clock_loss_alarm_i, strobe_position_alarm_i});
      wr(AMMLG_ALARM_OUTPUT_MASK_ADDR, m);
      outs(1'b0, 1'b1);
      wr(AMMLG_MUTE_MASK_ADDR, m);
      outs(1'b0, 1'b0);
      wr(AMMLG_ALARM_OUTPUT_MASK_ADDR, 8'h00);
      outs(1'b1, 1'b0);
      wr(AMMLG_MUTE_MASK_ADDR, 8'h00);
      fifo_empty_alarm_i      <= 4'h0;
      fifo_full_alarm_i       <= 4'h0;
      lane_clock_loss_alarm_i <= 4'h0;
      strobe_position_alarm_i <= 4'h0;
      outs(1'b0, 1'b0);
    end
  endtask

  task automatic t_reserved();
    wr(AMMLG_ALARM_OUTPUT_MASK_ADDR, 8'h18);
    wr(AMMLG_MUTE_MASK_ADDR, 8'h18);
    wr(AMMLG_SYS_ALARM_ADDR, 8'hF8);
    rd(AMMLG_ALARM_OUTPUT_MASK_ADDR, 8'h18);
    rd(AMMLG_MUTE_MASK_ADDR, 8'h18);
    rd(AMMLG_SYS_ALARM_ADDR, 8'hF8);
    chk("alarm_output_mask_o", alarm_output_mask_o, 8'h18);
    outs(1'b0, 1'b0);
    wr(AMMLG_NEIGH_ADDR0, 8'hFF);
    rd(AMMLG_NEIGH_ADDR0, 8'h00);
    rd(12'h0900, 8'h00);
    // Reset in mid-run brings back the defaults
    @(posedge clk_i);
    srst_i <= 1'b1;
    @(posedge clk_i);
    srst_i <= 1'b0;
    rd(AMMLG_SYS_ALARM_ADDR, 8'h00);
    rd(AMMLG_ALARM_OUTPUT_MASK_ADDR, 8'h00);
    rd(AMMLG_MUTE_MASK_ADDR, 8'h07);
  endtask

  initial
  begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_flags();
    t_sysmask();
    t_bank();
    t_reserved();
    end_of_test();
  end
endmodule
